/* src/psrc_ctrl.sv */
module psrc_ctrl
   import psrc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // User control
   input wire logic [1:0] temp_band,
   input wire logic [1:0] bank_sel,
   input wire logic sleep_req,
   // Status
   output logic [1:0] active_bank,
   output logic in_self_refresh,
   output logic cbr_tick,
   // Device pins, one request line per bank
   output logic [3:0] self_refresh_request_n,
   output logic row_strobe_n
);
   typedef enum logic [2:0] {
      PSRC_NORMAL = 3'h1,
      PSRC_SELF = 3'h2,
      PSRC_SWITCH = 3'h4
   } psrc_state_e;

   psrc_state_e state_ff;
   logic [STROBE_CNT_W-1:0] gap_ff;
   logic [31:0] cbr_ff;
   logic [1:0] active_bank_ff;
   logic cbr_tick_ff;
   logic strobe_due;
   logic pace_due;
   logic awake;
   logic fire_req;
   psrc_strobe_if stb ();

   // Slow-cycle limit for a band; hotter bands need faster strobes
   function automatic logic [STROBE_CNT_W-1:0] slow_limit(input logic [1:0] band);
      case (band)
         TBAND_50C: slow_limit = STROBE_CNT_W'(PERIOD_50C_CYC);
         TBAND_60C: slow_limit = STROBE_CNT_W'(PERIOD_60C_CYC);
         default: slow_limit = STROBE_CNT_W'(PERIOD_70C_CYC);
      endcase
   endfunction : slow_limit

   // Launch point: one full pulse must still fit before the limit runs out
   // One extra bit keeps the sum from wrapping near saturation
   function automatic logic gap_near_limit(input logic [STROBE_CNT_W-1:0] gap, input logic [1:0] band);
      gap_near_limit = ({1'b0, gap} + {1'b0, STROBE_CNT_W'(STROBE_BUSY_CYC + STROBE_MARGIN_CYC)})
         >= {1'b0, slow_limit(band)};
   endfunction : gap_near_limit

   // Pacing counter has reached the normal-mode refresh interval
   function automatic logic interval_done(input logic [31:0] count);
      interval_done = (count >= 32'(NORM_INTERVAL_CYC - 1));
   endfunction : interval_done

   // Request lines with at most one awake bank; the rest stay asleep
   function automatic logic [3:0] bank_lines(input logic [1:0] bank, input logic wake);
      bank_lines = 4'h0;
      if (wake) begin
         bank_lines[bank] = 1'b1;
      end
   endfunction : bank_lines

   psrc_strobe_gen u_gen (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .req(stb.gen),
      .row_strobe_n(row_strobe_n)
   );

   // Mode sequencing; a bank change passes through self-refresh for all
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= PSRC_SELF;
      end else begin
         case (state_ff)
            PSRC_NORMAL: begin
               if (sleep_req) begin
                  state_ff <= PSRC_SELF;
               end else if (bank_sel != active_bank_ff) begin
                  state_ff <= PSRC_SWITCH;
               end
            end
            PSRC_SELF: begin
               if (!sleep_req) begin
                  state_ff <= PSRC_NORMAL;
               end
            end
            // A sleep request during the one-cycle switch still wins
            PSRC_SWITCH: begin
               if (sleep_req) begin
                  state_ff <= PSRC_SELF;
               end else begin
                  state_ff <= PSRC_NORMAL;
               end
            end
            default: begin
               state_ff <= PSRC_SELF;
            end
         endcase
      end
   end

   // Active bank follows the selection only on the way into normal mode
   // Holding it while awake means a bank never changes without a sleep step
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         active_bank_ff <= 2'h0;
      end else if (!sleep_req && state_ff != PSRC_NORMAL) begin
         active_bank_ff <= bank_sel;
      end
   end

   // Normal mode decode, shared by the pins and the pacing logic
   assign awake = (state_ff == PSRC_NORMAL);

   always_comb begin
      self_refresh_request_n = bank_lines(active_bank_ff, awake);
   end

   // strobe gap bound; also spans mode changes
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gap_ff <= '0;
      end else if (stb.fire) begin
         gap_ff <= '0;
      end else if (gap_ff != '1) begin
         gap_ff <= gap_ff + 1'b1;
      end
   end

   // Strobe whenever the slow limit nears; margin covers the pulse length
   assign strobe_due = gap_near_limit(gap_ff, temp_band);
   // Pacing is only owed while a bank is awake
   assign pace_due = awake && interval_done(cbr_ff);

   // normal refresh pacing, 512 per 32 ms
   // Counter saturates, so a due pacing strobe waits out a busy generator
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cbr_ff <= '0;
      end else if (pace_due && !stb.busy) begin
         cbr_ff <= '0;
      end else if (!interval_done(cbr_ff)) begin
         cbr_ff <= cbr_ff + 1'b1;
      end
   end

   // tick marks the launch edge of a pacing strobe
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cbr_tick_ff <= 1'b0;
      end else begin
         cbr_tick_ff <= pace_due && !stb.busy;
      end
   end

   // Launch: the slow limit and pacing share one generator
   // A request while busy is simply held; the generator is never queued
   always_comb begin
      fire_req = 1'b0;
      if (!stb.busy) begin
         if (strobe_due) begin
            fire_req = 1'b1;
         end else if (pace_due) begin
            fire_req = 1'b1;
         end
      end
   end

   assign stb.fire = fire_req;

   // Status outputs
   assign active_bank = active_bank_ff;
   assign in_self_refresh = !awake;
   assign cbr_tick = cbr_tick_ff;
endmodule : psrc_ctrl

/* src/psrc_pkg.sv */
package psrc_pkg;
   // Clock rate in kHz, period 10 ns
   localparam int CLK_KHZ = 100000;
   // Slow-cycle limits in microseconds per temperature band
   localparam int PERIOD_50C_US = 20;
   localparam int PERIOD_60C_US = 10;
   localparam int PERIOD_70C_US = 5;
   // Longest times round down to whole cycles
   localparam int PERIOD_50C_CYC = PERIOD_50C_US * (CLK_KHZ / 1000);
   localparam int PERIOD_60C_CYC = PERIOD_60C_US * (CLK_KHZ / 1000);
   localparam int PERIOD_70C_CYC = PERIOD_70C_US * (CLK_KHZ / 1000);
   // Normal-mode refresh budget: 512 refreshes every 32 ms
   localparam int NORM_WINDOW_MS = 32;
   localparam int NORM_REFRESHES = 512;
   localparam int NORM_INTERVAL_CYC = (NORM_WINDOW_MS * CLK_KHZ) / NORM_REFRESHES;
   // Strobe low time in cycles
   localparam int STROBE_LOW_CYC = 60;
   // Generator busy time: low phase plus an equal recovery
   localparam int STROBE_BUSY_CYC = 2 * STROBE_LOW_CYC;
   // Extra launch slack for the request and load edges
   localparam int STROBE_MARGIN_CYC = 2;
   localparam int STROBE_CNT_W = 16;
   // Temperature band codes
   localparam logic [1:0] TBAND_50C = 2'h0;
   localparam logic [1:0] TBAND_60C = 2'h1;
   localparam logic [1:0] TBAND_70C = 2'h2;
endpackage : psrc_pkg

/* src/psrc_strobe_gen.sv */
// Makes one row strobe low pulse per request
module psrc_strobe_gen
   import psrc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Request side
   psrc_strobe_if.gen req,
   // Strobe pin
   output logic row_strobe_n
);
   logic [STROBE_CNT_W-1:0] cnt_ff;
   logic low_ff;

   // Pulse timer; busy covers low phase and recovery
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= '0;
         low_ff <= 1'b0;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1;
         // Load edge is itself a low cycle, so end one count early
         if (cnt_ff == STROBE_CNT_W'(STROBE_LOW_CYC + 1)) begin
            low_ff <= 1'b0;
         end
      end else if (req.fire) begin
         cnt_ff <= STROBE_CNT_W'(STROBE_BUSY_CYC);
         low_ff <= 1'b1;
      end
   end

   assign req.busy = (cnt_ff != '0);
   assign row_strobe_n = ~low_ff;
endmodule : psrc_strobe_gen

/* src/psrc_strobe_if.sv */
// Request to and answer from the strobe pulse generator
interface psrc_strobe_if;
   logic fire;
   logic busy;
   modport ctrl (output fire, input busy);
   modport gen (input fire, output busy);
endinterface : psrc_strobe_if

/* verif/psrc_chk_sva.sv */
module psrc_chk
   import psrc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Watched ports
   input wire logic sleep_req,
   input wire logic cbr_tick,
   input wire logic [3:0] self_refresh_request_n,
   input wire logic row_strobe_n
);
   timeunit 1ns / 1ns;
   int gap_ff;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Cycles since last strobe fall; band-blind, the bench checks each band
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) gap_ff <= 0;
      else gap_ff <= $fell(row_strobe_n) ? 0 : gap_ff + 1;
   end
   a_gap_limit: assert property (gap_ff < PERIOD_50C_CYC) else $error("gap");
   a_low_width: assert property ($rose(row_strobe_n) |-> !$past(row_strobe_n, 60) && $past(row_strobe_n, 61))
      else $error("low width");
   a_high_min: assert property ($rose(row_strobe_n) |-> row_strobe_n [*8]) else $error("high width");
   a_sleep_entry: assert property (sleep_req [*2] |-> self_refresh_request_n == 4'h0) else $error("sleep");
   a_one_bank: assert property ($onehot0(self_refresh_request_n)) else $error("banks");
   a_tick_pulse: assert property (cbr_tick |=> !cbr_tick) else $error("tick");
   a_tick_strobe: assert property (cbr_tick |-> $fell(row_strobe_n)) else $error("tick strobe");
   cover property ($rose(row_strobe_n));
   cover property (cbr_tick);
   cover property ($fell(sleep_req));
endmodule : psrc_chk
bind psrc_ctrl psrc_chk u_chk (
   .sys_clk(sys_clk),
   .sys_rst(sys_rst),
   .sleep_req(sleep_req),
   .cbr_tick(cbr_tick),
   .self_refresh_request_n(self_refresh_request_n),
   .row_strobe_n(row_strobe_n)
);

/* verif/psrc_dev_model.sv */
module psrc_dev_model (
   // Device pins
   input wire logic req_n,
   input wire logic strobe_n,
   // Rows refreshed so far
   output logic [8:0] row_ff = 9'h0,
   // High once the entry delay has passed in self-refresh
   output logic settled = 1'b0
);
   timeunit 1ns / 1ns;
   // Entry delay of 2.5 ms before true self-refresh
   localparam longint ENTRY_DELAY_NS = 2500000;
   logic [4:0] div_ff = 5'h0;
   time fall_t = 0;
   always @(negedge req_n) begin
      div_ff = 5'h0;
      fall_t = $time;
   end
   // only the strobe reaches the divider while asleep
   always @(negedge strobe_n) begin
      div_ff = req_n || div_ff == 5'h12 ? 5'h0 : div_ff + 5'h1;
      row_ff = row_ff + 9'(div_ff == 5'h0); // Awake banks count every pulse
      // true self-refresh only after the entry delay
      settled = !req_n && ($time - fall_t >= ENTRY_DELAY_NS);
   end
endmodule : psrc_dev_model

/* verif/tb.sv */
module tb;
   timeunit 1ns / 1ns;
   import psrc_pkg::*;
   logic sys_clk = 1'b0, sys_rst = 1'b1, sleep_req = 1'b1, in_self_refresh, cbr_tick, row_strobe_n, prev, dev_settled;
   logic [1:0] temp_band = 2'h3, bank_sel = 2'h0, active_bank;
   logic [3:0] self_refresh_request_n;
   logic [8:0] row, r;
   int errors = 0, cmp_count = 0, n;
   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;
   psrc_ctrl uut (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .temp_band(temp_band),
      .bank_sel(bank_sel),
      .sleep_req(sleep_req),
      .active_bank(active_bank),
      .in_self_refresh(in_self_refresh),
      .cbr_tick(cbr_tick),
      .self_refresh_request_n(self_refresh_request_n),
      .row_strobe_n(row_strobe_n)
   );
   psrc_dev_model dev (
      .req_n(self_refresh_request_n[0]),
      .strobe_n(row_strobe_n),
      .row_ff(row),
      .settled(dev_settled)
   );
   task automatic chk(input logic [8:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   // Next strobe fall; capped so a stuck strobe ends the run
   task automatic fall();
      n = 0;
      do begin
         prev = row_strobe_n;
         @(negedge sys_clk);
      end while ((prev !== 1'b1 || row_strobe_n !== 1'b0) && ++n < 3000);
      if (n < 3000) return;
      errors++;
      stop_test();
   endtask : fall
   // Next pacing tick; capped so a silent pacer ends the run
   task automatic tick_wait();
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (cbr_tick !== 1'b1 && n < 2 * NORM_INTERVAL_CYC);
      if (cbr_tick === 1'b1) return;
      errors++;
      stop_test();
   endtask : tick_wait
   // Sleep in each band; limits only widen so no gap is cut short
   task automatic sleep_bands();
      for (int i = 3; i >= 0; i--) begin
         temp_band = 2'(i);
         fall();
         r = row;
         repeat (i > 1 ? 19 : 4) begin
            fall();
            chk(n < (i == 0 ? PERIOD_50C_CYC : i == 1 ? PERIOD_60C_CYC : PERIOD_70C_CYC), 1);
         end
         if (i > 1) chk(row, r + 9'h1);
      end
      chk(dev_settled, 1'b0);
   endtask : sleep_bands
   // Wake each bank in turn, await two pacing ticks, then sleep again
   task automatic banks();
      sleep_req = 1'b0;
      for (int k = 0; k < 4; k++) begin
         bank_sel = 2'(k);
         repeat (4) @(negedge sys_clk);
         chk({active_bank, self_refresh_request_n}, {2'(k), 4'(1 << k)});
      end
      tick_wait();
      chk(cbr_tick, 1);
      tick_wait();
      chk(n >= NORM_INTERVAL_CYC && n <= NORM_INTERVAL_CYC + 2 * STROBE_LOW_CYC, 1);
      sleep_req = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk({in_self_refresh, self_refresh_request_n}, 5'h10);
   endtask : banks
   // Reset for 20 cycles, then the scenarios
   initial begin
      repeat (20) @(negedge sys_clk);
      chk({self_refresh_request_n, row_strobe_n, cbr_tick}, 6'h02);
      sys_rst = 1'b0;
      sleep_bands();
      banks();
      stop_test();
   end
endmodule : tb
